// ### core/pwmg_core.sv
`timescale 1ns/1ps
module pwmg_core (
	input wire logic  ref_clk,
	input wire logic  reset,
	pwmg_core_if.core cif
);
	import pwmg_pkg::*;

	logic [CNT_W-1:0] work_period;
	logic [CNT_W-1:0] work_duty [NUM_CH];
	pwmg_dir_t        dir;
	logic             top_hit;

	// Period boundaries
	assign top_hit = (cif.count >= work_period);
	assign cif.mid_pt = cif.run & cif.center & (dir == DIR_UP) & top_hit;
	assign cif.end_pt = cif.run & (cif.center
		? ((dir == DIR_DOWN) & (cif.count <= CNT_ONE))
			| (work_period == CNT_ZERO)
		: top_hit);
	assign cif.load_done = cif.load_req & (~cif.run | cif.end_pt);
	assign cif.clr_done  = cif.clr_req;

	// Counter, edge-aligned wrap or centre-aligned up and down
	always_ff @(posedge ref_clk) begin
		if (reset || cif.clr_req || !cif.run) begin
			cif.count <= CNT_ZERO;
			dir       <= DIR_UP;
		end else if (!cif.center) begin
			cif.count <= top_hit ? CNT_ZERO : cif.count + CNT_ONE;
		end else if (dir == DIR_UP) begin
			if (work_period == CNT_ZERO) begin
				cif.count <= CNT_ZERO;
			end else if (top_hit) begin
				dir       <= DIR_DOWN;
				cif.count <= cif.count - CNT_ONE;
			end else begin
				cif.count <= cif.count + CNT_ONE;
			end
		end else begin
			if (cif.count <= CNT_ONE) begin
				dir       <= DIR_UP;
				cif.count <= CNT_ZERO;
			end else begin
				cif.count <= cif.count - CNT_ONE;
			end
		end
	end

	// Working buffers follow registers when idle, else load at period end on a load request
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			work_period <= CNT_ZERO;
			for (int i = 0; i < NUM_CH; i++) begin
				work_duty[i] <= CNT_ZERO;
			end
		end else if (!cif.run || cif.load_done) begin
			work_period <= cif.period;
			for (int i = 0; i < NUM_CH; i++) begin
				work_duty[i] <= cif.duty[i];
			end
		end
	end

	// Output compare per channel
	for (genvar g = 0; g < NUM_CH; g++) begin : g_cmp
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				cif.gen[g] <= 1'b0;
			end else begin
				cif.gen[g] <= cif.run & (cif.count < work_duty[g]);
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_idle_outputs: assert property (
		(!cif.run)[*2] |-> (cif.gen == '0 && cif.count == CNT_ZERO))
		else $error("outputs or counter active while idle");
	a_edge_wrap: assert property (
		cif.run && !cif.center && !cif.clr_req && top_hit
		|=> cif.count == CNT_ZERO)
		else $error("counter did not restart at period");
	a_idle_track: assert property (
		!cif.run |=> work_period == $past(cif.period))
		else $error("working period not tracking while idle");

endmodule : pwmg_core

// ### core/pwmg_core_if.sv
`timescale 1ns/1ps
interface pwmg_core_if;
	import pwmg_pkg::*;

	logic             run;
	logic             center;
	logic             load_req;
	logic             clr_req;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] duty [NUM_CH];
	logic [CNT_W-1:0] count;
	logic             load_done;
	logic             clr_done;
	logic             mid_pt;
	logic             end_pt;
	logic [NUM_CH-1:0] gen;

	modport ctrl (output run, center, load_req, clr_req, period, duty,
		input count, load_done, clr_done, mid_pt, end_pt, gen);
	modport core (input run, center, load_req, clr_req, period, duty,
		output count, load_done, clr_done, mid_pt, end_pt, gen);

endinterface : pwmg_core_if

// ### core/pwmg_pkg.sv
package pwmg_pkg;

	// Register addresses on the byte-wide register port
	localparam logic [7:0] ADDR_INTC = 8'hb7;
	localparam logic [7:0] ADDR_PERH = 8'hd1;
	localparam logic [7:0] ADDR_D0H  = 8'hd2;
	localparam logic [7:0] ADDR_D1H  = 8'hd3;
	localparam logic [7:0] ADDR_D2H  = 8'hd4;
	localparam logic [7:0] ADDR_CON0 = 8'hd8;
	localparam logic [7:0] ADDR_PERL = 8'hd9;
	localparam logic [7:0] ADDR_D0L  = 8'hda;
	localparam logic [7:0] ADDR_D1L  = 8'hdb;
	localparam logic [7:0] ADDR_D2L  = 8'hdc;
	localparam logic [7:0] ADDR_MODE = 8'hdd;
	localparam logic [7:0] ADDR_STAT = 8'hde;
	localparam logic [7:0] ADDR_MASK = 8'hdf;

	// Field positions
	localparam int CON_RUN    = 7;
	localparam int CON_LOAD   = 6;
	localparam int CON_FLAG   = 5;
	localparam int CON_CLR    = 4;
	localparam int TYP_HI     = 5;
	localparam int TYP_LO     = 4;
	localparam int SEL_HI     = 2;
	localparam int SEL_LO     = 0;
	localparam int MODE_CTR   = 0;
	localparam int EV_FLAG    = 0;
	localparam int EV_END     = 1;
	localparam int EV_LOAD    = 2;

	// Sizes and constants
	localparam int NUM_CH     = 3;
	localparam int NUM_SEL    = 6;
	localparam int NUM_EV     = 3;
	localparam int CNT_W      = 16;
	localparam logic [7:0]       BYTE_RST = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
	localparam logic [2:0]       SEL_MAX  = 3'h5;
	localparam logic [2:0]       SEL_DEF  = 3'h0;

	typedef enum logic [1:0] {
		TYP_FALL = 2'h0,
		TYP_RISE = 2'h1,
		TYP_MID  = 2'h2,
		TYP_END  = 2'h3
	} pwmg_irq_type_t;

	typedef enum logic {
		DIR_UP   = 1'h0,
		DIR_DOWN = 1'h1
	} pwmg_dir_t;

endpackage : pwmg_pkg

// ### core/pwmg_top.sv
`timescale 1ns/1ps
module pwmg_top (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	output logic             gen_out0,
	output logic             gen_out1,
	output logic             gen_out2,
	output logic             irq
);
	import pwmg_pkg::*;

	pwmg_core_if cif ();

	logic [CNT_W-1:0]   period_value;
	logic [CNT_W-1:0]   duty_value [NUM_CH];
	pwmg_irq_type_t     irq_event_type;
	logic [2:0]         irq_channel_select;
	logic               run_enable;
	logic               load_pend;
	logic               generator_flag;
	logic               counter_clear;
	logic               center_mode;
	logic [NUM_EV-1:0]  irq_status;
	logic [NUM_EV-1:0]  irq_mask;
	logic [NUM_SEL-1:0] chan_lvl;
	logic [NUM_SEL-1:0] prev_lvl;
	logic [2:0]         sel_idx;
	logic               cur_lvl;
	logic               old_lvl;
	logic               flag_event;
	logic [NUM_EV-1:0]  events;
	logic               wr_con;
	logic [7:0]         next_rdata;

	// Core connection
	assign cif.run      = run_enable;
	assign cif.center   = center_mode;
	assign cif.load_req = load_pend;
	assign cif.clr_req  = counter_clear;
	assign cif.period   = period_value;
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			cif.duty[i] = duty_value[i];
		end
	end

	pwmg_core u_core (
		.ref_clk (ref_clk),
		.reset   (reset),
		.cif     (cif)
	);

	// Pins driven from the core's compare flops
	assign gen_out0 = cif.gen[0];
	assign gen_out1 = cif.gen[1];
	assign gen_out2 = cif.gen[2];

	assign wr_con = reg_wr && (reg_addr == ADDR_CON0);

	// Period bytes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			period_value <= {BYTE_RST, BYTE_RST};
		end else if (reg_wr && reg_addr == ADDR_PERH) begin
			period_value[15:8] <= reg_wdata;
		end else if (reg_wr && reg_addr == ADDR_PERL) begin
			period_value[7:0] <= reg_wdata;
		end
	end

	// Duty bytes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_value[i] <= {BYTE_RST, BYTE_RST};
			end
		end else if (reg_wr) begin
			unique case (reg_addr)
				ADDR_D0H: duty_value[0][15:8] <= reg_wdata;
				ADDR_D1H: duty_value[1][15:8] <= reg_wdata;
				ADDR_D2H: duty_value[2][15:8] <= reg_wdata;
				ADDR_D0L: duty_value[0][7:0]  <= reg_wdata;
				ADDR_D1L: duty_value[1][7:0]  <= reg_wdata;
				ADDR_D2L: duty_value[2][7:0]  <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Interrupt control and mode
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_event_type     <= TYP_FALL;
			irq_channel_select <= SEL_DEF;
			center_mode        <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_INTC) begin
			irq_event_type     <= pwmg_irq_type_t'(reg_wdata[TYP_HI:TYP_LO]);
			irq_channel_select <= reg_wdata[SEL_HI:SEL_LO];
		end else if (reg_wr && reg_addr == ADDR_MODE) begin
			center_mode <= reg_wdata[MODE_CTR];
		end
	end

	// Run enable
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			run_enable <= 1'b0;
		end else if (wr_con) begin
			run_enable <= reg_wdata[CON_RUN];
		end
	end

	// Load request: a new request wins over completion in one cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			load_pend <= 1'b0;
		end else if (wr_con && reg_wdata[CON_LOAD]) begin
			load_pend <= 1'b1;
		end else if (cif.load_done) begin
			load_pend <= 1'b0;
		end
	end

	// Counter clear request, self clearing after one cycle
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			counter_clear <= 1'b0;
		end else if (wr_con && reg_wdata[CON_CLR]) begin
			counter_clear <= 1'b1;
		end else if (cif.clr_done) begin
			counter_clear <= 1'b0;
		end
	end

	// Channel levels: 3 to 5 are the complements of 0 to 2 while running
	assign chan_lvl = {cif.gen & {NUM_CH{run_enable}} ^ {NUM_CH{run_enable}},
		cif.gen};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prev_lvl <= '0;
		end else begin
			prev_lvl <= chan_lvl;
		end
	end

	// Channel pick with fallback to channel 0
	assign sel_idx = (irq_channel_select > SEL_MAX) ? SEL_DEF
		: irq_channel_select;
	assign cur_lvl = chan_lvl[sel_idx];
	assign old_lvl = prev_lvl[sel_idx];

	// Flag event source
	always_comb begin
		unique case (irq_event_type)
			TYP_FALL: flag_event = old_lvl & ~cur_lvl;
			TYP_RISE: flag_event = cur_lvl & ~old_lvl;
			TYP_MID:  flag_event = center_mode & cif.mid_pt;
			TYP_END:  flag_event = center_mode & cif.end_pt;
		endcase
	end

	// Generator flag: sticky, cleared by writing 0, a new event wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			generator_flag <= 1'b0;
		end else if (flag_event) begin
			generator_flag <= 1'b1;
		end else if (wr_con && !reg_wdata[CON_FLAG]) begin
			generator_flag <= 1'b0;
		end
	end

	// Interrupt status, write one to clear, events win
	assign events[EV_FLAG] = flag_event;
	assign events[EV_END]  = cif.end_pt;
	assign events[EV_LOAD] = cif.load_done;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_status <= '0;
		end else if (reg_wr && reg_addr == ADDR_STAT) begin
			irq_status <= (irq_status & ~reg_wdata[NUM_EV-1:0]) | events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	// Interrupt mask
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq_mask <= '0;
		end else if (reg_wr && reg_addr == ADDR_MASK) begin
			irq_mask <= reg_wdata[NUM_EV-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// Read data mux
	always_comb begin
		next_rdata = BYTE_RST;
		unique case (reg_addr)
			ADDR_INTC: begin
				next_rdata[TYP_HI:TYP_LO] = irq_event_type;
				next_rdata[SEL_HI:SEL_LO] = irq_channel_select;
			end
			ADDR_PERH: next_rdata = period_value[15:8];
			ADDR_PERL: next_rdata = period_value[7:0];
			ADDR_D0H:  next_rdata = duty_value[0][15:8];
			ADDR_D1H:  next_rdata = duty_value[1][15:8];
			ADDR_D2H:  next_rdata = duty_value[2][15:8];
			ADDR_D0L:  next_rdata = duty_value[0][7:0];
			ADDR_D1L:  next_rdata = duty_value[1][7:0];
			ADDR_D2L:  next_rdata = duty_value[2][7:0];
			ADDR_CON0: begin
				next_rdata[CON_RUN]  = run_enable;
				next_rdata[CON_LOAD] = load_pend;
				next_rdata[CON_FLAG] = generator_flag;
				next_rdata[CON_CLR]  = counter_clear;
			end
			ADDR_MODE: next_rdata[MODE_CTR] = center_mode;
			ADDR_STAT: next_rdata[NUM_EV-1:0] = irq_status;
			ADDR_MASK: next_rdata[NUM_EV-1:0] = irq_mask;
			default:   next_rdata = BYTE_RST;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= BYTE_RST;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= BYTE_RST;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_period_high_byte: assert property (
		reg_wr && reg_addr == ADDR_PERH
		|=> period_value[15:8] == $past(reg_wdata))
		else $error("period high byte not stored");

	a_duty_low_byte: assert property (
		reg_wr && reg_addr == ADDR_D1L
		|=> duty_value[1][7:0] == $past(reg_wdata))
		else $error("duty low byte not stored");

	a_run_store: assert property (
		wr_con
		|=> run_enable == $past(reg_wdata[CON_RUN]))
		else $error("run enable not stored");

	a_load_request: assert property (
		wr_con && reg_wdata[CON_LOAD]
		|=> load_pend)
		else $error("load request not taken");

	a_load_copy: assert property (
		load_pend && cif.load_done
		|=> u_core.work_period == $past(period_value))
		else $error("period not copied on load");

	a_load_pending: assert property (
		load_pend && !cif.load_done |=> load_pend)
		else $error("load bit dropped before transfer");

	a_load_finish: assert property (
		load_pend && cif.load_done && !wr_con |=> !load_pend)
		else $error("load bit not cleared after transfer");

	a_clear_request: assert property (
		wr_con && reg_wdata[CON_CLR]
		|=> counter_clear)
		else $error("counter clear request not taken");

	a_clear_cycle: assert property (
		wr_con && reg_wdata[CON_CLR] ##1 !wr_con
		|-> counter_clear ##1 (!counter_clear && cif.count == CNT_ZERO))
		else $error("counter clear sequence wrong");

	a_flag_sticky: assert property (
		generator_flag && !wr_con |=> generator_flag)
		else $error("flag cleared without software");

	a_flag_clear: assert property (
		wr_con && !reg_wdata[CON_FLAG] && !flag_event
		|=> !generator_flag)
		else $error("flag not cleared by software");

	a_rise_event: assert property (
		irq_event_type == TYP_RISE && $stable(sel_idx)
		&& $rose(chan_lvl[sel_idx]) |=> generator_flag)
		else $error("rising edge did not set flag");

	a_fall_event: assert property (
		irq_event_type == TYP_FALL && $stable(sel_idx)
		&& $fell(chan_lvl[sel_idx]) |=> generator_flag)
		else $error("falling edge did not set flag");

	a_centre_event: assert property (
		irq_event_type == TYP_MID && center_mode && cif.mid_pt
		|=> generator_flag)
		else $error("centre point did not set flag");

	a_end_event: assert property (
		irq_event_type == TYP_END && center_mode && cif.end_pt
		|=> generator_flag)
		else $error("end point did not set flag");

	a_edge_only_mode: assert property (
		irq_event_type[1] && !center_mode && !generator_flag
		|=> !generator_flag)
		else $error("period event flagged outside centre mode");

	a_sel_fallback: assert property (
		irq_channel_select > SEL_MAX |-> sel_idx == SEL_DEF)
		else $error("illegal channel code not mapped to channel 0");

	a_sel_pick: assert property (
		irq_channel_select <= SEL_MAX
		|-> sel_idx == irq_channel_select)
		else $error("legal channel code not picked");

	a_read_slot: assert property (
		!reg_rd |=> reg_rdata == BYTE_RST)
		else $error("read data outside its slot");

endmodule : pwmg_top

// ### testbench/pwmg_pin_load.sv
`timescale 1ns/1ps
// Loads on the three generator pins: high cycles counted over a window
module pwmg_pin_load (
	input  wire logic        ref_clk,
	input  wire logic        win,
	input  wire logic        gen_out0,
	input  wire logic        gen_out1,
	input  wire logic        gen_out2,
	output logic      [15:0] hi0,
	output logic      [15:0] hi1,
	output logic      [15:0] hi2
);
	// Counts restart whenever the window is closed
	always_ff @(posedge ref_clk) begin
		hi0 <= win ? hi0 + {15'h0000, gen_out0} : 16'h0000;
		hi1 <= win ? hi1 + {15'h0000, gen_out1} : 16'h0000;
		hi2 <= win ? hi2 + {15'h0000, gen_out2} : 16'h0000;
	end
endmodule : pwmg_pin_load

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
	import pwmg_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
	logic        ref_clk   = 1'b0;
	logic        reset     = 1'b1;
	logic [7:0]  reg_addr  = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [7:0]  reg_rdata;
	logic        gen_out0, gen_out1, gen_out2, irq;
	logic        win       = 1'b0;
	logic [15:0] hi0, hi1, hi2;
	logic [31:0] lfsr_q    = 32'hcf683458;
	logic [7:0]  d;
	logic [31:0] r;
	logic [15:0] p, d0, d1, d2;
	int          miscompares = 0;
	int          tests_run   = 0;
	logic [7:0]  addrs [14] = '{ADDR_INTC, ADDR_PERH, ADDR_D0H, ADDR_D1H,
		ADDR_D2H, ADDR_CON0, ADDR_PERL, ADDR_D0L, ADDR_D1L, ADDR_D2L,
		ADDR_MODE, ADDR_STAT, ADDR_MASK, 8'h10};

	pwmg_top i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .gen_out0(gen_out0), .gen_out1(gen_out1),
		.gen_out2(gen_out2), .irq(irq));
	pwmg_pin_load i_load (.ref_clk(ref_clk), .win(win), .gen_out0(gen_out0),
		.gen_out1(gen_out1), .gen_out2(gen_out2), .hi0(hi0), .hi1(hi1),
		.hi2(hi2));

	// 25 MHz clock
	always #20 ref_clk = ~ref_clk;

	// High cycles of one output over one whole period
	function logic [15:0] exp_high(input logic [15:0] dt,
		input logic [15:0] pr);
		return (dt > pr) ? pr + 16'h0001 : dt;
	endfunction : exp_high

	// Channel 2 and its complement never toggle with a zero duty
	function logic exp_flag(input logic [2:0] sel);
		logic [2:0] ch;
		ch = (sel > SEL_MAX) ? SEL_DEF : sel;
		return (ch != 3'h2) && (ch != 3'h5);
	endfunction : exp_flag

	// Next value of the stimulus shift register
	function logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0],
			lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction : rnd

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		@(negedge ref_clk);
		v = reg_rdata;
	endtask : rd

	task set16(input logic [7:0] ah, input logic [7:0] al,
		input logic [15:0] v);
		wr(ah, v[15:8]);
		wr(al, v[7:0]);
	endtask : set16

	task set_all(input logic [15:0] pr, input logic [15:0] a,
		input logic [15:0] b, input logic [15:0] c);
		set16(ADDR_PERH, ADDR_PERL, pr);
		set16(ADDR_D0H, ADDR_D0L, a);
		set16(ADDR_D1H, ADDR_D1L, b);
		set16(ADDR_D2H, ADDR_D2L, c);
	endtask : set_all

	task measure(input int n);
		win <= 1'b1;
		repeat (n) @(posedge ref_clk);
		win <= 1'b0;
		@(negedge ref_clk);
	endtask : measure

	// Bounded poll until a self-clearing bit reads back 0
	task wait_clear(input logic [7:0] a, input int b);
		int i;
		for (i = 0; i < 100; i++) begin
			rd(a, d);
			if (d[b] === 1'b0)
				break;
		end
		`CHK(i < 100, 1'b1)
		if (i == 100)
			results();
	endtask : wait_clear

	task flag_case(input logic [7:0] ic, input logic [7:0] md, input logic e,
		input int w);
		wr(ADDR_MODE, md);
		wr(ADDR_INTC, ic);
		wr(ADDR_CON0, 8'h80);
		repeat (w) @(posedge ref_clk);
		rd(ADDR_CON0, d);
		`CHK(d[CON_FLAG], e)
	endtask : flag_case

	task tend(input string n);
		$display("test %s done", n);
	endtask : tend

	task results;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// Hang guard
	initial begin
		#2000000;
		miscompares++;
		results();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (addrs[i]) begin
			rd(addrs[i], d);
			`CHK(d, 8'h00)
		end
		wr(8'h10, 8'h5a);
		rd(8'h10, d);
		`CHK(d, 8'h00)
		tend("reset_values");
		for (int k = 0; k < 4; k++) begin
			r = rnd();
			p  = {12'h000, 4'h4 + r[3:0]};
			d0 = {11'h000, r[8:4]};
			d1 = {11'h000, r[13:9]};
			d2 = {11'h000, r[18:14]};
			if (k == 0) begin
				p  = 16'h0102;
				d0 = 16'h0100;
				d1 = 16'h0000;
				d2 = 16'h0200;
			end
			set_all(p, d0, d1, d2);
			measure(int'(p) + 1);
			`CHK(hi0 | hi1 | hi2, 16'h0000)
			wr(ADDR_CON0, 8'h80);
			repeat (3) @(posedge ref_clk);
			measure(int'(p) + 1);
			`CHK(hi0, exp_high(d0, p))
			`CHK(hi1, exp_high(d1, p))
			`CHK(hi2, exp_high(d2, p))
			wr(ADDR_CON0, 8'h00);
		end
		tend("duty_period");
		set_all(16'h0028, 16'h000a, 16'h0000, 16'h0000);
		wr(ADDR_CON0, 8'h80);
		wr(ADDR_D0L, 8'h1e);
		wr(ADDR_CON0, 8'hc0);
		rd(ADDR_CON0, d);
		`CHK(d[CON_LOAD], 1'b1)
		wait_clear(ADDR_CON0, CON_LOAD);
		measure(41);
		`CHK(hi0, 16'h001e)
		rd(ADDR_STAT, d);
		`CHK(d, 8'h07)
		tend("load");
		wr(ADDR_D0L, 8'h14);
		wr(ADDR_CON0, 8'hc0);
		wait_clear(ADDR_CON0, CON_LOAD);
		wr(ADDR_CON0, 8'h90);
		wait_clear(ADDR_CON0, CON_CLR);
		measure(12);
		`CHK(hi0, 16'h000c)
		tend("counter_clear");
		wr(ADDR_CON0, 8'h00);
		set_all(16'h0005, 16'h0001, 16'h0003, 16'h0000);
		wr(ADDR_CON0, 8'h80);
		for (int t = 0; t < 2; t++)
			for (int s = 0; s < 8; s++)
				flag_case({2'h0, t[1:0], 1'b0, s[2:0]}, 8'h00,
					exp_flag(s[2:0]), 10);
		for (int t = 2; t < 4; t++)
			for (int m = 0; m < 2; m++)
				flag_case({2'h0, t[1:0], 4'h0}, {7'h00, m[0]}, m[0], 20);
		tend("flag_events");
		wr(ADDR_MASK, 8'h01);
		flag_case(8'h10, 8'h00, 1'b1, 10);
		@(negedge ref_clk);
		`CHK(irq, 1'b1)
		wr(ADDR_MASK, 8'h00);
		@(negedge ref_clk);
		`CHK(irq, 1'b0)
		wr(ADDR_MASK, 8'h01);
		wr(ADDR_CON0, 8'h20);
		repeat (8) @(posedge ref_clk);
		rd(ADDR_CON0, d);
		`CHK(d[CON_FLAG], 1'b1)
		wr(ADDR_STAT, 8'h07);
		wr(ADDR_CON0, 8'h00);
		@(negedge ref_clk);
		`CHK(irq, 1'b0)
		rd(ADDR_CON0, d);
		`CHK(d, 8'h00)
		tend("interrupt");
		results();
	end
endmodule : tb
